// file: design/devcap_reg.sv
// Purpose: Read-only device capability register behind an APB slave
// Assumes: Slot power messages arrive decoded on pclk; straps are async pins
// Notes:   Zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none

module devcap_reg #(
  parameter logic [2:0] PAYLOAD_CODE = devcap_pkg::PAYLOAD_RST,
  parameter logic [2:0] LAT0_CODE    = devcap_pkg::LAT_RST,
  parameter logic [2:0] LAT1_CODE    = devcap_pkg::LAT_RST
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [devcap_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          hotplug_strap,
  input  wire logic                          forward_mode,
  input  wire logic                          spl_msg_valid,
  input  wire logic [7:0]                    spl_msg_value,
  input  wire logic [1:0]                    spl_msg_scale
);
  import devcap_pkg::*;

  // ============================================================
  // Elaboration checks
  if (PAYLOAD_CODE > PAYLOAD_MAX) begin : g_bad_payload
    $error("payload code is a reserved encoding");
  end

  // ============================================================
  // Decode
  function automatic logic cap_hit(input logic [ADDR_W-1:0] a);
    cap_hit = (a[ADDR_W-1:2] == DEVCAP_OFFSET[ADDR_W-1:2]);
  endfunction : cap_hit

  // ============================================================
  // Strap synchronisers
  logic [1:0] hp_sync_q;
  logic [1:0] fwd_sync_q;
  logic [1:0] settle_q;
  logic       strap_done_q;
  logic       hp_q;
  logic       fwd_q;
  logic       hp_on;

  // Two stages; only the second stage is read downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_sync_q  <= 2'h0;
      fwd_sync_q <= 2'h0;
    end else begin
      hp_sync_q  <= {hp_sync_q[0], hotplug_strap};
      fwd_sync_q <= {fwd_sync_q[0], forward_mode};
    end
  end

  // Wait for the synchronisers to fill before trusting straps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 2'h0;
    end else if (settle_q != STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Straps are taken once; later pin wiggles are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'b0;
      hp_q         <= 1'b0;
      fwd_q        <= 1'b0;
    end else if (!strap_done_q && settle_q == STRAP_SETTLE) begin
      strap_done_q <= 1'b1;
      hp_q         <= hp_sync_q[1];
      fwd_q        <= fwd_sync_q[1];
    end
  end

  assign hp_on = hp_q & fwd_q; // R6

  // ============================================================
  // Captured slot power limit
  logic [7:0] splv_q;
  logic [1:0] spls_q;

  // Only a message updates these; software has no path in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      splv_q <= SPLV_RST;
      spls_q <= SPLS_RST;
    end else if (spl_msg_valid) begin
      splv_q <= spl_msg_value; // R7
      spls_q <= spl_msg_scale; // R8
    end
  end

  // ============================================================
  // Register word
  logic [31:0] cap_word;

  // Reserved bits stay zero by construction
  always_comb begin
    cap_word = 32'h0000_0000; // R9
    cap_word[PAYLOAD_LSB +: 3] = PAYLOAD_CODE; // R1
    cap_word[PHANTOM_LSB +: 2] = PHANTOM_VAL; // R2
    cap_word[XTAG_BIT]         = XTAG_VAL; // R3
    cap_word[LAT0_LSB +: 3]    = LAT0_CODE; // R4
    cap_word[LAT1_LSB +: 3]    = LAT1_CODE; // R5
    cap_word[ABTN_BIT]         = hp_on; // R6
    cap_word[AIND_BIT]         = hp_on; // R6
    cap_word[PIND_BIT]         = hp_on; // R6
    cap_word[SPLV_LSB +: 8]    = splv_q; // R7
    cap_word[SPLS_LSB +: 2]    = spls_q; // R8
  end

  // ============================================================
  // APB slave
  logic        setup;
  logic [31:0] rdata_q;
  logic        err_q;

  assign setup  = psel & ~penable;
  assign pready = 1'b1; // Never stalls

  // Data is staged in setup so the access phase shows a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      rdata_q <= (!pwrite && cap_hit(paddr)) ? cap_word : 32'h0000_0000;
    end
  end

  // Writes to the capability word are accepted and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= ~cap_hit(paddr); // R9
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = err_q & psel & penable;

  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_acc;
  assign rd_acc = psel & penable & ~pwrite & cap_hit(paddr);

  AST_PAYLOAD: assert property (rd_acc |-> prdata[2:0] == PAYLOAD_CODE) // R1
    else $error("payload field wrong");
  AST_PHANTOM: assert property (rd_acc |-> prdata[4:3] == 2'h0) // R2
    else $error("phantom field not zero");
  AST_XTAG: assert property (rd_acc |-> prdata[5]) // R3
    else $error("extended tag bit clear");
  AST_LAT0: assert property (rd_acc |-> prdata[8:6] == LAT0_CODE) // R4
    else $error("shallow latency field wrong");
  AST_LAT1: assert property (rd_acc |-> prdata[11:9] == LAT1_CODE) // R5
    else $error("deep latency field wrong");
  AST_HOTPLUG: assert property (rd_acc && $stable(hp_on)
    |-> prdata[14:12] == {3{hp_q & fwd_q}}) // R6
    else $error("hot-plug bits wrong");
  AST_HP_GATE: assert property (!fwd_q |-> cap_word[14:12] == 3'h0) // R6
    else $error("hot-plug bits set in reverse mode");
  AST_SPLV: assert property (spl_msg_valid |=> splv_q == $past(spl_msg_value)) // R7
    else $error("power value not captured");
  AST_SPLS: assert property (!spl_msg_valid |=> $stable(spls_q) && $stable(splv_q)) // R8
    else $error("power fields moved without a message");
  AST_RSVD: assert property (psel && penable |-> (prdata & RSVD_MASK) == 32'h0) // R9
    else $error("reserved bits nonzero");
  AST_WR_NOEFF: assert property (psel && penable && pwrite && !spl_msg_valid && strap_done_q
    |=> $stable(cap_word)) // R9
    else $error("write changed the register");
  AST_RD_DATA: assert property (setup && !pwrite && cap_hit(paddr) && !spl_msg_valid
    ##1 penable |-> prdata == $past(cap_word)) // R1
    else $error("read data not the staged word");

  // ============================================================
  // Bus protocol checks
  // Slave never stalls, so masters need no wait logic
  AST_PREADY: assert property (pready)
    else $error("pready dropped");

  // Error response only ever appears in an access phase
  AST_ERR_ACCESS: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");

  // Unmapped words are refused
  AST_ERR_UNMAPPED: assert property (psel && penable && !cap_hit(paddr) |-> pslverr)
    else $error("unmapped access not refused");

  // Accesses to the register complete as OKAY, writes included
  AST_OKAY_MAPPED: assert property (psel && penable && cap_hit(paddr) |-> !pslverr) // R9
    else $error("mapped access refused");

  // Writes return zero data, never the register word
  AST_WR_ZERO: assert property (psel && penable && pwrite |-> prdata == 32'h0) // R9
    else $error("write returned data");

  // Unmapped reads leak nothing
  AST_UNMAPPED_ZERO: assert property (psel && penable && !cap_hit(paddr) |-> prdata == 32'h0)
    else $error("unmapped read returned data");

  // Read data stands until the next setup edge
  AST_RDATA_HOLD: assert property (!setup |=> $stable(rdata_q))
    else $error("read data moved outside setup");

  // ============================================================
  // Strap checks
  // Second stage follows the first by one cycle
  AST_SYNC_HP: assert property (hp_sync_q[1] == $past(hp_sync_q[0])) // R6
    else $error("hot-plug synchroniser skipped a stage");

  // Same for the bridge direction strap
  AST_SYNC_FWD: assert property (fwd_sync_q[1] == $past(fwd_sync_q[0])) // R6
    else $error("direction synchroniser skipped a stage");

  // Settle counter parks at its limit
  AST_SETTLE_HOLD: assert property (settle_q == STRAP_SETTLE |=> settle_q == STRAP_SETTLE)
    else $error("settle counter left its limit");

  // Latch takes the synchronised straps when settled
  AST_LATCH_TAKES: assert property (!strap_done_q && settle_q == STRAP_SETTLE
    |=> hp_q == $past(hp_sync_q[1]) && fwd_q == $past(fwd_sync_q[1])) // R6
    else $error("straps not latched from synchronisers");

  // Straps are taken once; pin noise later has no effect
  AST_STRAP_ONCE: assert property (strap_done_q |=> strap_done_q && $stable(hp_on)) // R6
    else $error("hot-plug state moved after latch");

  // Before the latch the hot-plug bits read zero
  AST_HP_EARLY: assert property (!strap_done_q |-> !hp_on) // R6
    else $error("hot-plug bits set before straps settled");

  // Hot-plug strap off forces the bits low
  AST_HP_NOPLUG: assert property (!hp_q |-> cap_word[14:12] == 3'h0) // R6
    else $error("hot-plug bits set with strap off");

  // The three presence bits always agree
  AST_HP_SAME: assert property (cap_word[14:12] == 3'h0
    || cap_word[14:12] == 3'h7) // R6
    else $error("hot-plug bits disagree");

  // ============================================================
  // Register word checks
  // Parameter check keeps the code legal; this guards the word too
  AST_PAYLOAD_LEGAL: assert property (cap_word[2:0] <= PAYLOAD_MAX) // R1
    else $error("payload code reserved");

  // Phantom field is fixed
  AST_PHANTOM_WORD: assert property (cap_word[4:3] == PHANTOM_VAL) // R2
    else $error("phantom field not fixed");

  // Extended tag bit is fixed
  AST_XTAG_WORD: assert property (cap_word[5] == XTAG_VAL) // R3
    else $error("extended tag bit not fixed");

  // Shallow latency field follows its parameter
  AST_LAT0_WORD: assert property (cap_word[8:6] == LAT0_CODE) // R4
    else $error("shallow latency field not fixed");

  // Deep latency field follows its parameter
  AST_LAT1_WORD: assert property (cap_word[11:9] == LAT1_CODE) // R5
    else $error("deep latency field not fixed");

  // Captured value lands in its field
  AST_SPLV_WORD: assert property (cap_word[25:18] == splv_q) // R7
    else $error("power value field misplaced");

  // Captured scale lands in its field
  AST_SPLS_WORD: assert property (cap_word[27:26] == spls_q) // R8
    else $error("power scale field misplaced");

  // A message loads the scale on its own edge
  AST_SPLS_CAP: assert property (spl_msg_valid |=> spls_q == $past(spl_msg_scale)) // R8
    else $error("power scale not captured");

  // Reserved bits are zero in the word itself
  AST_RSVD_WORD: assert property ((cap_word & RSVD_MASK) == 32'h0) // R9
    else $error("reserved bits nonzero in word");

  COV_READ: cover property (rd_acc);
  COV_MSG_READ: cover property (spl_msg_valid ##2 rd_acc);
  COV_HP_ON: cover property (rd_acc && prdata[12]);
  COV_UNMAPPED: cover property (psel && penable && pslverr);
  COV_WRITE: cover property (psel && penable && pwrite && !pslverr);

endmodule : devcap_reg

`default_nettype wire

// file: design/devcap_pkg.sv
// Purpose: Constants for the device capability register block
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   Field positions and reset values live here; assertions and bench repeat them as literals
// ============================================================
// Overview of operation
// R1: Bits 2:0 read the payload capability code, 000=128 up to 101=4096 bytes, reset 001.
// R2: Bits 4:3 read 00, meaning no phantom functions.
// R3: Bit 5 reads 1, meaning eight-bit tags are supported.
// R4: Bits 8:6 read the shallow low-power exit latency code, reset 000.
// R5: Bits 11:9 read the deep low-power exit latency code, reset 000.
// R6: Bits 12..14 read 1 only with hot-plug strapped on and forward mode, else 0.
// R7: Bits 25:18 load the value of a received slot power limit message, reset 00h.
// R8: Bits 27:26 load the scale of a received slot power limit message, reset 00.
// R9: Writes change nothing and bits 17:15 and 31:28 read zero.
package devcap_pkg;

  // ============================================================
  // Register map
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] DEVCAP_OFFSET = 12'h0B4;

  // ============================================================
  // Field positions
  localparam int PAYLOAD_LSB = 0;
  localparam int PHANTOM_LSB = 3;
  localparam int XTAG_BIT    = 5;
  localparam int LAT0_LSB    = 6;
  localparam int LAT1_LSB    = 9;
  localparam int ABTN_BIT    = 12;
  localparam int AIND_BIT    = 13;
  localparam int PIND_BIT    = 14;
  localparam int SPLV_LSB    = 18;
  localparam int SPLS_LSB    = 26;

  // ============================================================
  // Reset and fixed values
  localparam logic [2:0] PAYLOAD_RST = 3'h1;
  localparam logic [2:0] PAYLOAD_MAX = 3'h5;
  localparam logic [1:0] PHANTOM_VAL = 2'h0;
  localparam logic       XTAG_VAL    = 1'h1;
  localparam logic [2:0] LAT_RST     = 3'h0;
  localparam logic [7:0] SPLV_RST    = 8'h00;
  localparam logic [1:0] SPLS_RST    = 2'h0;
  localparam logic [31:0] RSVD_MASK  = 32'hF003_8000;

  // ============================================================
  // Strap settle time after reset release, in cycles
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : devcap_pkg

// file: sim/test_device_capability_register.sv
// Purpose: Self-checking bench for the capability register
// Assumes: Zero-wait APB slave; straps latched once after reset
// Notes:   Random message payloads and write data from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module test_device_capability_register;
  import devcap_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic        er, hotplug_strap, forward_mode, spl_msg_valid;
  logic [7:0]  spl_msg_value, v;
  logic [1:0]  spl_msg_scale, s;
  logic [11:0] a;
  integer      seed, bad_count, compares, i;

  devcap_reg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hotplug_strap(hotplug_strap), .forward_mode(forward_mode),
    .spl_msg_valid(spl_msg_valid), .spl_msg_value(spl_msg_value),
    .spl_msg_scale(spl_msg_scale));

  // ============================================================
  // Clock, 50 ns period
  always #25 pclk = ~pclk;

  // Expected word; hot-plug bits need both straps
  function automatic logic [31:0] exp_word(input logic hp, input logic fw,
                                           input logic [7:0] pv, input logic [1:0] ps);
    exp_word = {4'h0, ps, pv, 3'h0, {3{hp & fw}}, 3'h0, 3'h0, 1'h1, 2'h0, 3'h1};
  endfunction : exp_word

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_err(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_err

  // Straps change only under reset, so the latch sees them settled
  task automatic rst(input logic hp, input logic fw);
    presetn <= 1'h0;
    hotplug_strap <= hp;
    forward_mode <= fw;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
  endtask : rst

  // One APB transfer; waits on pready, bounded by the watchdog
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic msg(input logic [7:0] mv, input logic [1:0] ms);
    spl_msg_valid <= 1'h1;
    spl_msg_value <= mv;
    spl_msg_scale <= ms;
    @(posedge pclk);
  endtask : msg

  task automatic report_and_stop;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ============================================================
  // Watchdog: whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count = bad_count + 1;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {hotplug_strap, forward_mode, spl_msg_valid, spl_msg_value, spl_msg_scale} = '0;
    seed = 32'h6A29487D;
    bad_count = 0;
    compares = 0;
    // Every strap combination, fixed fields after reset
    for (i = 0; i < 4; i++) begin
      rst(i[1], i[0]);
      apb(1'h0, 12'h0B4, 32'h0);
      chk(rd, exp_word(i[1], i[0], 8'h00, 2'h0));
    end
    // Messages, some back to back where the last one wins
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      s = (i == 0) ? 2'h3 : 2'($random(seed));
      if (i[0]) msg(~v, ~s);
      msg(v, s);
      spl_msg_valid <= 1'h0;
      apb(1'h0, 12'h0B4, 32'h0);
      chk(rd, exp_word(1'h1, 1'h1, v, s));
    end
    // Write is ignored; low address bits do not matter
    wd = $random(seed);
    apb(1'h1, 12'h0B4, wd);
    chk_err(er, 1'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h0B7, 32'h0);
    chk(rd, exp_word(1'h1, 1'h1, v, s));
    // Unmapped address is refused with zero data
    a = 12'($random(seed));
    if (a[11:2] == 10'h2D) a = a ^ 12'h100;
    apb(1'h0, a, 32'h0);
    chk_err(er, 1'h1);
    chk(rd, 32'h0);
    // Reset clears captured power fields
    rst(1'h1, 1'h1);
    apb(1'h0, 12'h0B4, 32'h0);
    chk(rd, exp_word(1'h1, 1'h1, SPLV_RST, SPLS_RST));
    report_and_stop();
  end
endmodule : test_device_capability_register

`default_nettype wire
